// file: logic/vpic_pkg.sv
// Package with register map, field layout and state type of the vectored priority interrupt controller
package vpic_pkg;

    localparam int unsigned SRC_N    = 8;
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned IDX_W    = 14;
    localparam int unsigned STAT_W   = 3;
    localparam int unsigned VEC_W    = 4;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_REQ_G0   = 14'h0fc0;
    localparam logic [IDX_W-1:0] IDX_ENH_G0   = 14'h0fc1;
    localparam logic [IDX_W-1:0] IDX_ENL_G0   = 14'h0fc2;
    localparam logic [IDX_W-1:0] IDX_REQ_PIN  = 14'h0fc3;
    localparam logic [IDX_W-1:0] IDX_ENH_PIN  = 14'h0fc4;
    localparam logic [IDX_W-1:0] IDX_ENL_PIN  = 14'h0fc5;
    localparam logic [IDX_W-1:0] IDX_EDGE_SEL = 14'h0fcd;
    localparam logic [IDX_W-1:0] IDX_PORT_SEL = 14'h0fce;
    localparam logic [IDX_W-1:0] IDX_CTRL     = 14'h0fcf;
    localparam logic [IDX_W-1:0] IDX_STATUS   = 14'h0fd0;
    localparam logic [IDX_W-1:0] IDX_MASK     = 14'h0fd1;

    // Field positions
    localparam int unsigned CTRL_IEN_BIT  = 7;
    localparam int unsigned STAT_POLL_BIT = 0;
    localparam int unsigned STAT_ACK_BIT  = 1;
    localparam int unsigned STAT_PIN_BIT  = 2;

    localparam logic [1:0] LVL_OFF = 2'h0;

    // Core side commands, one-cycle pulses
    typedef struct packed {
        logic ei;
        logic di;
        logic reti;
        logic ack;
    } vpic_core_cmd_type;

    typedef struct packed {
        logic [SRC_N-1:0]  pa_s1;
        logic [SRC_N-1:0]  pa_s2;
        logic [SRC_N-1:0]  pd_s1;
        logic [SRC_N-1:0]  pd_s2;
        logic [SRC_N-1:0]  pin_prev;
        logic [SRC_N-1:0]  req_g0;
        logic [SRC_N-1:0]  enh_g0;
        logic [SRC_N-1:0]  enl_g0;
        logic [SRC_N-1:0]  req_pin;
        logic [SRC_N-1:0]  enh_pin;
        logic [SRC_N-1:0]  enl_pin;
        logic [SRC_N-1:0]  edge_sel;
        logic [SRC_N-1:0]  port_sel;
        logic              ien;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic              vec_req;
        logic [VEC_W-1:0]  vec_id;
        logic              irq_out;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
    } vpic_state_type;

    localparam vpic_state_type RESET_STATE = '0;

endpackage

// file: logic/vpic_top.sv
// Vectored priority interrupt controller with APB register slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module vpic_top
(
    // Clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             rst_n,
    // APB slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [vpic_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // Peripheral requests, bit 7 timer 2 down to bit 0 converter
    input  wire logic [vpic_pkg::SRC_N-1:0]       periph_req,
    // Port pins, asynchronous
    input  wire logic [vpic_pkg::SRC_N-1:0]       port_a_pin,
    input  wire logic [vpic_pkg::SRC_N-1:0]       port_d_pin,
    // Processor core
    input  wire vpic_pkg::vpic_core_cmd_type      core_cmd,
    output logic                                  vec_req,
    output logic      [vpic_pkg::VEC_W-1:0]       vec_id,
    output logic                                  master_irq_enable,
    output logic                                  irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    vpic_pkg::vpic_state_type q;
    vpic_pkg::vpic_state_type n;

    logic [vpic_pkg::SRC_N-1:0]  selected_port_pin;
    logic [vpic_pkg::SRC_N-1:0]  edge_hit;
    logic [2*vpic_pkg::SRC_N-1:0] pend_all;
    logic [2*vpic_pkg::SRC_N-1:0] enh_all;
    logic [2*vpic_pkg::SRC_N-1:0] enl_all;
    logic [2*vpic_pkg::SRC_N-1:0] ack_clr;
    logic [vpic_pkg::VEC_W:0]     pick;
    logic [vpic_pkg::IDX_W-1:0]   idx;
    logic                         setup;
    logic                         wr;
    logic                         ack_ok;
    logic                         ien_set;

    // Best pending source: highest level, higher index on a tie
    function automatic logic [vpic_pkg::VEC_W:0] pick_src(
        input logic [2*vpic_pkg::SRC_N-1:0] pend,
        input logic [2*vpic_pkg::SRC_N-1:0] hi,
        input logic [2*vpic_pkg::SRC_N-1:0] lo
    );
        logic [1:0]                lvl;
        logic [1:0]                best;
        logic [vpic_pkg::VEC_W:0]  r;
        best = vpic_pkg::LVL_OFF;
        r    = '0;
        for (int i = 0; i < 2*vpic_pkg::SRC_N; i++)
        begin
            lvl = {hi[i], lo[i]};
            if (pend[i] && lvl != vpic_pkg::LVL_OFF && lvl >= best)
            begin
                best = lvl;
                r    = {1'b1, vpic_pkg::VEC_W'(i)};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin source choice and edge detect on synchronised pins
    assign selected_port_pin = (q.port_sel & q.pd_s2) | (~q.port_sel & q.pa_s2);
    assign edge_hit = (q.edge_sel & selected_port_pin & ~q.pin_prev)
                    | (~q.edge_sel & ~selected_port_pin & q.pin_prev);

    // Watchdog is not a source: only group 0 and the pin group take part
    assign pend_all = {q.req_g0, q.req_pin};
    assign enh_all  = {q.enh_g0, q.enh_pin};
    assign enl_all  = {q.enl_g0, q.enl_pin};
    assign pick     = pick_src(pend_all, enh_all, enl_all);

    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite & q.pready & ~q.pslverr;
    assign idx     = paddr[vpic_pkg::ADDR_W-1:2];
    assign ack_ok  = core_cmd.ack & q.vec_req;
    assign ack_clr = (2*vpic_pkg::SRC_N)'(1) << q.vec_id;
    assign ien_set = core_cmd.ei | core_cmd.reti | (wr && idx == vpic_pkg::IDX_CTRL
                     && pwdata[vpic_pkg::CTRL_IEN_BIT]);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        n = q;
        // Two-stage synchronisers; pulses must outlast one clock
        n.pa_s1    = port_a_pin;
        n.pa_s2    = q.pa_s1;
        n.pd_s1    = port_d_pin;
        n.pd_s2    = q.pd_s1;
        n.pin_prev = selected_port_pin;

        // APB answer, one access cycle after setup
        n.pready  = setup;
        n.pslverr = 1'b0;
        n.prdata  = '0;
        if (setup)
        begin
            if (paddr[1:0] != 2'h0)
            begin
                n.pslverr = 1'b1;
            end
            else
            begin
                case (idx)
                    vpic_pkg::IDX_REQ_G0:   n.prdata[7:0] = q.req_g0;
                    vpic_pkg::IDX_ENH_G0:   n.prdata[7:0] = q.enh_g0;
                    vpic_pkg::IDX_ENL_G0:   n.prdata[7:0] = q.enl_g0;
                    vpic_pkg::IDX_REQ_PIN:  n.prdata[7:0] = q.req_pin;
                    vpic_pkg::IDX_ENH_PIN:  n.prdata[7:0] = q.enh_pin;
                    vpic_pkg::IDX_ENL_PIN:  n.prdata[7:0] = q.enl_pin;
                    vpic_pkg::IDX_EDGE_SEL: n.prdata[7:0] = q.edge_sel;
                    vpic_pkg::IDX_PORT_SEL: n.prdata[7:0] = q.port_sel;
                    vpic_pkg::IDX_CTRL:     n.prdata[vpic_pkg::CTRL_IEN_BIT] = q.ien;
                    vpic_pkg::IDX_STATUS:   n.prdata[vpic_pkg::STAT_W-1:0] = q.status;
                    vpic_pkg::IDX_MASK:     n.prdata[vpic_pkg::STAT_W-1:0] = q.mask;
                    default:                n.pslverr = 1'b1;
                endcase
            end
        end

        // Software writes at the access edge
        if (wr)
        begin
            case (idx)
                vpic_pkg::IDX_REQ_G0:   n.req_g0   = pwdata[7:0];
                vpic_pkg::IDX_ENH_G0:   n.enh_g0   = pwdata[7:0];
                vpic_pkg::IDX_ENL_G0:   n.enl_g0   = pwdata[7:0];
                vpic_pkg::IDX_REQ_PIN:  n.req_pin  = pwdata[7:0];
                vpic_pkg::IDX_ENH_PIN:  n.enh_pin  = pwdata[7:0];
                vpic_pkg::IDX_ENL_PIN:  n.enl_pin  = pwdata[7:0];
                vpic_pkg::IDX_EDGE_SEL: n.edge_sel = pwdata[7:0];
                vpic_pkg::IDX_PORT_SEL: n.port_sel = pwdata[7:0];
                vpic_pkg::IDX_CTRL:     n.ien      = pwdata[vpic_pkg::CTRL_IEN_BIT];
                vpic_pkg::IDX_STATUS:   n.status   = q.status & ~pwdata[vpic_pkg::STAT_W-1:0];
                vpic_pkg::IDX_MASK:     n.mask     = pwdata[vpic_pkg::STAT_W-1:0];
                default:                n.mask     = q.mask;
            endcase
        end

        // Acknowledge clears the served source and the global enable
        if (ack_ok)
        begin
            n.req_g0  = n.req_g0 & ~ack_clr[2*vpic_pkg::SRC_N-1:vpic_pkg::SRC_N];
            n.req_pin = n.req_pin & ~ack_clr[vpic_pkg::SRC_N-1:0];
            n.ien     = 1'b0;
        end
        if (core_cmd.di)
        begin
            n.ien = 1'b0;
        end
        if (core_cmd.ei || core_cmd.reti)
        begin
            n.ien = 1'b1;
        end

        // New requests win over any clear in the same cycle
        n.req_g0  = n.req_g0 | periph_req;
        n.req_pin = n.req_pin | edge_hit;

        // Sticky events, set wins over clear
        n.status[vpic_pkg::STAT_POLL_BIT] = n.status[vpic_pkg::STAT_POLL_BIT]
                                          | (~q.ien & ((|periph_req) | (|edge_hit)));
        n.status[vpic_pkg::STAT_ACK_BIT]  = n.status[vpic_pkg::STAT_ACK_BIT] | ack_ok;
        n.status[vpic_pkg::STAT_PIN_BIT]  = n.status[vpic_pkg::STAT_PIN_BIT] | (|edge_hit);
        n.irq_out = |(n.status & n.mask);

        // Vector delivery, withheld in the cycle of an acknowledge or disable
        n.vec_req = q.ien & pick[vpic_pkg::VEC_W] & ~ack_ok & ~core_cmd.di;
        n.vec_id  = pick[vpic_pkg::VEC_W-1:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            q <= vpic_pkg::RESET_STATE;
        end
        else
        begin
            q <= n;
        end
    end

    assign prdata            = q.prdata;
    assign pready            = q.pready;
    assign pslverr           = q.pslverr;
    assign vec_req           = q.vec_req;
    assign vec_id            = q.vec_id;
    assign master_irq_enable = q.ien;
    assign irq_out           = q.irq_out;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ien_on;
        core_cmd.ei || core_cmd.reti;
    endsequence

    sequence s_src_quiet;
        !core_cmd.di && !ack_ok && q.ien;
    endsequence

    property p_ien_set;
        s_ien_on |=> q.ien ##1 (q.ien || !$past(ien_set));
    endproperty
    a_ien_set: assert property (p_ien_set) else $error("global enable not set");

    property p_ien_clr;
        (core_cmd.di || ack_ok) && !ien_set |=> !q.ien && !master_irq_enable;
    endproperty
    a_ien_clr: assert property (p_ien_clr) else $error("global enable not cleared");

    property p_req_set;
        (|periph_req) |=> ((q.req_g0 & $past(periph_req)) == $past(periph_req));
    endproperty
    a_req_set: assert property (p_req_set) else $error("request bit not latched");

    property p_fwd;
        s_src_quiet and pick[vpic_pkg::VEC_W] |=> vec_req && vec_id == $past(pick[vpic_pkg::VEC_W-1:0]);
    endproperty
    a_fwd: assert property (p_fwd) else $error("pending request not forwarded");

    property p_no_fwd;
        !q.ien |=> !vec_req;
    endproperty
    a_no_fwd: assert property (p_no_fwd) else $error("request forwarded while disabled");

    property p_all_off;
        (enh_all | enl_all) == '0 |=> !vec_req;
    endproperty
    a_all_off: assert property (p_all_off) else $error("disabled source forwarded");

    property p_level;
        vec_req && $past((enh_all & pend_all) != '0) |-> $past(enh_all[pick[vpic_pkg::VEC_W-1:0]]);
    endproperty
    a_level: assert property (p_level) else $error("priority order broken");

    property p_pin_edge;
        (|edge_hit) |=> ((q.req_pin & $past(edge_hit)) == $past(edge_hit)) ##1 irq_out || !q.mask[vpic_pkg::STAT_PIN_BIT];
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("pin edge not latched");

    property p_port_a_fall;
        !q.port_sel[0] && !q.edge_sel[0] && $stable(q.port_sel) && $stable(q.edge_sel) && $fell(q.pa_s2[0])
            |=> q.req_pin[0];
    endproperty
    a_port_a_fall: assert property (p_port_a_fall) else $error("port A falling edge missed");

    property p_ack_clr;
        ack_ok && !(|periph_req) && !(|edge_hit) |=> !pend_all[$past(q.vec_id)] && !vec_req;
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("acknowledged request not cleared");

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    property p_apb_answer;
        s_apb_setup |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("access not answered once");

    property p_rst_clr;
        disable iff (1'b0) !rst_n |=> !master_irq_enable && !vec_req && !irq_out;
    endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("reset left enable or request up");

    property p_ien_wr1;
        wr && idx == vpic_pkg::IDX_CTRL && pwdata[vpic_pkg::CTRL_IEN_BIT] && !core_cmd.di && !ack_ok
            |=> master_irq_enable;
    endproperty
    a_ien_wr1: assert property (p_ien_wr1) else $error("written one did not enable");

    property p_ien_wr0;
        wr && idx == vpic_pkg::IDX_CTRL && !pwdata[vpic_pkg::CTRL_IEN_BIT] && !core_cmd.ei && !core_cmd.reti
            |=> !master_irq_enable;
    endproperty
    a_ien_wr0: assert property (p_ien_wr0) else $error("written zero did not disable");

    property p_poll;
        !q.ien && (|periph_req) |=> q.status[vpic_pkg::STAT_POLL_BIT];
    endproperty
    a_poll: assert property (p_poll) else $error("polled request not flagged");

    property p_pin_stat;
        (|edge_hit) |=> q.status[vpic_pkg::STAT_PIN_BIT];
    endproperty
    a_pin_stat: assert property (p_pin_stat) else $error("pin edge not flagged");

    property p_port_d_rise;
        q.port_sel[1] && q.edge_sel[1] && $stable(q.port_sel) && $stable(q.edge_sel) && $rose(q.pd_s2[1])
            |=> q.req_pin[1];
    endproperty
    a_port_d_rise: assert property (p_port_d_rise) else $error("port D rising edge missed");

    property p_req_wr0;
        wr && idx == vpic_pkg::IDX_REQ_PIN && pwdata[vpic_pkg::SRC_N-1:0] == '0 && !(|edge_hit)
            |=> q.req_pin == '0;
    endproperty
    a_req_wr0: assert property (p_req_wr0) else $error("written zero left a request");

    property p_ack_stat;
        ack_ok |=> q.status[vpic_pkg::STAT_ACK_BIT];
    endproperty
    a_ack_stat: assert property (p_ack_stat) else $error("acknowledge not flagged");

endmodule

// file: dv/vpic_core_model.sv
// Processor core model issuing enable, disable, return and acknowledge pulses
`timescale 1ns/1ps
module vpic_core_model
(
    // Clock
    input  wire logic                        core_clk,
    // Interrupt controller side
    input  wire logic                        vec_req,
    output vpic_pkg::vpic_core_cmd_type      core_cmd
);
    initial core_cmd = '0;

    ////////////////////////////////////////////////////////////////////////////
    // One pulse after an optional stall; acknowledge only while a vector is up
    task automatic send(input logic [3:0] c, input int stall);
        logic [3:0] cmd;
        cmd = c;
        repeat (stall) @(posedge core_clk);
        @(posedge core_clk);
        if (vec_req !== 1'b1)
        begin
            cmd[0] = 1'b0;
        end
        core_cmd <= vpic_pkg::vpic_core_cmd_type'(cmd);
        @(posedge core_clk);
        core_cmd <= '0;
    endtask
endmodule

// file: dv/test_vpic_top.sv
// Self-checking bench of the vectored priority interrupt controller
`timescale 1ns/1ps
module test_vpic_top;
    localparam logic [15:0] A_REQ  = {vpic_pkg::IDX_REQ_G0, 2'h0};
    localparam logic [15:0] A_ENH  = {vpic_pkg::IDX_ENH_G0, 2'h0};
    localparam logic [15:0] A_ENL  = {vpic_pkg::IDX_ENL_G0, 2'h0};
    localparam logic [15:0] A_PREQ = {vpic_pkg::IDX_REQ_PIN, 2'h0};
    localparam logic [15:0] A_EDGE = {vpic_pkg::IDX_EDGE_SEL, 2'h0};
    localparam logic [15:0] A_PORT = {vpic_pkg::IDX_PORT_SEL, 2'h0};
    localparam logic [15:0] A_CTRL = {vpic_pkg::IDX_CTRL, 2'h0};
    localparam logic [15:0] A_STAT = {vpic_pkg::IDX_STATUS, 2'h0};
    localparam logic [15:0] A_MASK = {vpic_pkg::IDX_MASK, 2'h0};
    localparam logic [15:0] RST_A [5] = '{A_REQ, A_ENH, A_EDGE, A_PORT, A_CTRL};
    localparam logic [3:0]  IDS [3]   = '{4'hd, 4'hb, 4'hf};
    localparam logic [3:0]  CMDS [3]  = '{4'h8, 4'h2, 4'h2};

    logic                          core_clk   = 1'b0;
    logic                          rst_n      = 1'b0;
    logic                          psel       = 1'b0;
    logic                          penable    = 1'b0;
    logic                          pwrite     = 1'b0;
    logic [15:0]                   paddr      = '0;
    logic [31:0]                   pwdata     = '0;
    logic [7:0]                    periph_req = '0;
    logic [7:0]                    port_a_pin = '0;
    logic [7:0]                    port_d_pin = '0;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          vec_req;
    logic [3:0]                    vec_id;
    logic                          master_irq_enable;
    logic                          irq_out;
    vpic_pkg::vpic_core_cmd_type   core_cmd;
    logic [31:0]                   rd;
    logic                          err;
    int                            mismatches = 0;
    int                            n_checks   = 0;

    always #4 core_clk = ~core_clk;

    vpic_top dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_req(periph_req), .port_a_pin(port_a_pin), .port_d_pin(port_d_pin), .core_cmd(core_cmd),
        .vec_req(vec_req), .vec_id(vec_id), .master_irq_enable(master_irq_enable), .irq_out(irq_out));
    vpic_core_model core (.core_clk(core_clk), .vec_req(vec_req), .core_cmd(core_cmd));

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic hang(input string what);
        mismatches++;
        $display("unexpected at %0t: no %s", $time, what);
        test_done();
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            hang("pready");
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic wait_vec();
        int n;
        for (n = 0; n < 20 && vec_req !== 1'b1; n++)
            @(posedge core_clk);
        if (vec_req !== 1'b1)
            hang("vector");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(5);
        rst_n <= 1'b1;
        foreach (RST_A[i])
        begin
            apb(1'b0, RST_A[i], '0);
            chk32(rd, 32'h0);
        end
        chk1(master_irq_enable, 1'b0);
        apb(1'b0, 16'h0ffc, '0);
        chk1(err, 1'b1);
        wr(A_ENH, 32'ha5);
        apb(1'b0, A_ENH, '0);
        chk32(rd, 32'ha5);
        $display("test registers done");
        wr(A_CTRL, 32'h0);
        wr(A_REQ, 32'h0);
        wr(A_ENH, 32'h28);
        wr(A_ENL, 32'ha0);
        tick(1);
        periph_req <= 8'ha8;
        tick(1);
        periph_req <= 8'h00;
        apb(1'b0, A_REQ, '0);
        chk32(rd, 32'ha8);
        chk1(vec_req, 1'b0);
        chk1(irq_out, 1'b0);
        wr(A_MASK, 32'h1);
        tick(2);
        chk1(irq_out, 1'b1);
        wr(A_STAT, 32'h1);
        tick(2);
        chk1(irq_out, 1'b0);
        $display("test polling done");
        for (int i = 0; i < 3; i++)
        begin
            core.send(CMDS[i], i);
            wait_vec();
            chk1(master_irq_enable, 1'b1);
            chk32({28'h0, vec_id}, {28'h0, IDS[i]});
            core.send(4'h1, 2 - i);
            tick(2);
            chk1(vec_req, 1'b0);
            chk1(master_irq_enable, 1'b0);
        end
        apb(1'b0, A_REQ, '0);
        chk32(rd, 32'h0);
        wr(A_CTRL, 32'h80);
        tick(2);
        chk1(master_irq_enable, 1'b1);
        core.send(4'h4, 0);
        tick(2);
        chk1(master_irq_enable, 1'b0);
        wr(A_CTRL, 32'h80);
        wr(A_CTRL, 32'h0);
        tick(2);
        chk1(master_irq_enable, 1'b0);
        $display("test vectors done");
        wr(A_EDGE, 32'h02);
        wr(A_PORT, 32'h02);
        wr(A_STAT, 32'h7);
        tick(1);
        port_a_pin <= 8'h03;
        tick(3);
        port_a_pin <= 8'h00;
        tick(3);
        port_d_pin <= 8'h02;
        tick(3);
        port_d_pin <= 8'h00;
        tick(4);
        apb(1'b0, A_PREQ, '0);
        chk32(rd, 32'h03);
        apb(1'b0, A_STAT, '0);
        chk32(rd, 32'h5);
        wr(A_PREQ, 32'h0);
        apb(1'b0, A_PREQ, '0);
        chk32(rd, 32'h0);
        $display("test pins done");
        test_done();
    end
endmodule
